// File: inc/auxthr_pkg.sv
// Package for the auxiliary channel threshold detector: register map,
// field layouts, reset values and the sample carrier struct.
// Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
package auxthr_pkg;

	// ==========================================================
	// Register indices (printed offsets); byte address is 4x index
	localparam logic [7:0] AUXTHR_IDX_ACT_UPPER   = 8'h3e;
	localparam logic [7:0] AUXTHR_IDX_ACT_LOWER   = 8'h3f;
	localparam logic [7:0] AUXTHR_IDX_QUIET_UPPER = 8'h40;
	localparam logic [7:0] AUXTHR_IDX_QUIET_LOWER = 8'h41;
	localparam logic [7:0] AUXTHR_IDX_CTRL        = 8'h3d;
	localparam logic [7:0] AUXTHR_IDX_TIMER       = 8'h42;
	localparam logic [7:0] AUXTHR_IDX_STATUS      = 8'h50;
	localparam logic [7:0] AUXTHR_IDX_MASK        = 8'h51;
	localparam logic [7:0] AUXTHR_IDX_STATE       = 8'h52;

	// ==========================================================
	// Field layouts
	localparam int AUXTHR_THR_W     = 13;
	localparam int AUXTHR_SMP_W     = 14;
	localparam int AUXTHR_UPPER_W   = 7;
	localparam int AUXTHR_LOWER_W   = 6;
	localparam int AUXTHR_LOWER_LSB = 2;
	localparam int AUXTHR_CNT_W     = 4;
	localparam int AUXTHR_ACT_CNT_LSB   = 0;
	localparam int AUXTHR_QUIET_CNT_LSB = 4;
	// Control bits
	localparam int AUXTHR_CTL_TEMP_EN   = 0;
	localparam int AUXTHR_CTL_ACT_EN    = 1;
	localparam int AUXTHR_CTL_QUIET_EN  = 3;
	localparam int AUXTHR_CTL_EXT_EN    = 4;
	localparam logic [7:0] AUXTHR_CTL_WMASK = 8'h1b;
	// Status / mask bits
	localparam int AUXTHR_ST_ACT   = 0;
	localparam int AUXTHR_ST_QUIET = 1;
	localparam int AUXTHR_ST_W     = 2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] AUXTHR_RST_BYTE = 8'h00;

	// Sample handed in from the converter front end
	typedef struct packed {
		logic                           valid;
		logic                           is_temp;
		logic signed [AUXTHR_SMP_W-1:0] data;
	} auxthr_sample_s;

endpackage

// File: verilog/auxthr_cnt.sv
// Consecutive-sample counter: pulses once when a condition has held for
// the programmed number of samples, and again on every further hit if that number is all ones (saturated). Assumes one strobe per sample.
`timescale 1ns/1ps
`default_nettype none

module auxthr_cnt #(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Sample strobe and condition
	input  wire logic             smp_i,
	input  wire logic             hit_i,
	input  wire logic [CNT_W-1:0] need_i,
	// Detection pulse
	output logic                  evt_o
);
	// ==========================================================
	// Run length of consecutive hits, saturating
	logic [CNT_W-1:0] run_q;
	logic [CNT_W-1:0] run_d;
	logic             fire;

	// A count of zero fires on the first hit; fire only on reaching need
	assign run_d = !hit_i ? '0 : ((run_q == {CNT_W{1'b1}}) ? run_q : run_q + 1'b1);
	assign fire  = smp_i && hit_i && (run_d == need_i || (need_i == '0 && run_q == '0));

	// Run counter and event register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_q <= '0;
			evt_o <= 1'b0;
		end else begin
			evt_o <= fire;
			if (smp_i) begin
				run_q <= run_d;
			end
		end
	end
endmodule

`default_nettype wire

// File: verilog/auxthr_top.sv
// Auxiliary channel threshold detector with AHB-Lite register slave.
// Assumes samples arrive synchronous to CLK_SYS_I, one valid per ODR tick.
// Functional notes
// R1 - A sample is active when its magnitude is greater than the 13-bit activity threshold.
// R2 - A sample is inactive when its magnitude is less than the 13-bit inactivity threshold.
// R3 - The signed 14-bit sample is made absolute and compared with the unsigned threshold.
// R4 - Thresholds are raw codes, one step per code, with no scaling.
// R5 - Offset 0x3E holds activity threshold bits 12:6 in bits 6:0, bit 7 reserved, reset zero.
// R6 - Offset 0x3F holds activity threshold bits 5:0 in bits 7:2, bits 1:0 reserved, reset zero.
// R7 - Offset 0x40 holds inactivity threshold bits 12:6 in bits 6:0, bit 7 reserved, reset zero.
// R8 - Offset 0x41 holds inactivity threshold bits 5:0 in bits 7:2, bits 1:0 reserved, reset zero.
// R9 - Reserved threshold bits read zero and ignore writes; threshold fields are read-write.
// R10 - An activity event is raised only after the programmed count of consecutive active samples.
// R11 - An inactivity event is raised only after the programmed count of consecutive quiet samples.
// R12 - With temperature enabled the external converter stays off and its enable has no effect.
// R13 - Each threshold is the upper seven bits joined above the lower six bits.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module auxthr_top
	import auxthr_pkg::*;
#(
	parameter int HADDR_W = 32
) (
	// Clock and reset
	input  wire logic                      CLK_SYS_I,
	input  wire logic                      RST_I,
	// AHB-Lite slave
	input  wire logic                      HSEL_I,
	input  wire logic [HADDR_W-1:0]        HADDR_I,
	input  wire logic [1:0]                HTRANS_I,
	input  wire logic                      HWRITE_I,
	input  wire logic [2:0]                HSIZE_I,
	input  wire logic [31:0]               HWDATA_I,
	input  wire logic                      HREADY_I,
	output logic [31:0]                    HRDATA_O,
	output logic                           HREADYOUT_O,
	output logic                           HRESP_O,
	// Auxiliary samples
	input  wire auxthr_pkg::auxthr_sample_s SMP_I,
	// Detection outputs
	output logic                           EXT_CONV_EN_O,
	output logic                           ACT_EVT_O,
	output logic                           QUIET_EVT_O,
	output logic                           IRQ_O
);
	import auxthr_pkg::*;

	// ==========================================================
	// Parameter check
	if (HADDR_W < 11) begin : g_bad_addr
		$error("HADDR_W too small for the register map");
	end

	// ==========================================================
	// Register state
	logic [AUXTHR_UPPER_W-1:0] act_up_q, quiet_up_q;
	logic [AUXTHR_LOWER_W-1:0] act_lo_q, quiet_lo_q;
	logic [7:0]                ctl_q;
	logic [7:0]                timer_q;
	logic [AUXTHR_ST_W-1:0]    status_q;
	logic [AUXTHR_ST_W-1:0]    mask_q;

	// Data phase capture
	logic       wr_pend_q;
	logic [7:0] wr_idx_q;

	// ==========================================================
	// Bus address phase decode
	logic       addr_take;
	logic [7:0] addr_idx;
	logic       addr_word;
	assign addr_take = HSEL_I && HREADY_I && HTRANS_I[1];
	assign addr_idx  = HADDR_I[9:2];
	assign addr_word = (HADDR_I[1:0] == 2'b00) && (HADDR_I[HADDR_W-1:10] == '0);

	// Index to read data; unmapped words read zero
	function automatic logic [7:0] rd_byte(input logic [7:0] idx,
		input logic [AUXTHR_UPPER_W-1:0] au, input logic [AUXTHR_LOWER_W-1:0] al,
		input logic [AUXTHR_UPPER_W-1:0] qu, input logic [AUXTHR_LOWER_W-1:0] ql,
		input logic [7:0] ctl, input logic [7:0] tmr,
		input logic [AUXTHR_ST_W-1:0] st, input logic [AUXTHR_ST_W-1:0] mk,
		input logic [1:0] run);
		case (idx)
			AUXTHR_IDX_ACT_UPPER:   rd_byte = {1'b0, au};              // R5 R9
			AUXTHR_IDX_ACT_LOWER:   rd_byte = {al, 2'b00};             // R6 R9
			AUXTHR_IDX_QUIET_UPPER: rd_byte = {1'b0, qu};              // R7 R9
			AUXTHR_IDX_QUIET_LOWER: rd_byte = {ql, 2'b00};             // R8 R9
			AUXTHR_IDX_CTRL:        rd_byte = ctl;
			AUXTHR_IDX_TIMER:       rd_byte = tmr;
			AUXTHR_IDX_STATUS:      rd_byte = {6'h00, st};
			AUXTHR_IDX_MASK:        rd_byte = {6'h00, mk};
			AUXTHR_IDX_STATE:       rd_byte = {6'h00, run};
			default:                rd_byte = 8'h00;
		endcase
	endfunction

	// ==========================================================
	// Data phase write strobes
	logic [7:0] wbyte;
	logic       wr_act_up, wr_act_lo, wr_quiet_up, wr_quiet_lo;
	logic       wr_ctl, wr_timer, wr_status, wr_mask;
	assign wbyte       = HWDATA_I[7:0];
	assign wr_act_up   = wr_pend_q && (wr_idx_q == AUXTHR_IDX_ACT_UPPER);
	assign wr_act_lo   = wr_pend_q && (wr_idx_q == AUXTHR_IDX_ACT_LOWER);
	assign wr_quiet_up = wr_pend_q && (wr_idx_q == AUXTHR_IDX_QUIET_UPPER);
	assign wr_quiet_lo = wr_pend_q && (wr_idx_q == AUXTHR_IDX_QUIET_LOWER);
	assign wr_ctl      = wr_pend_q && (wr_idx_q == AUXTHR_IDX_CTRL);
	assign wr_timer    = wr_pend_q && (wr_idx_q == AUXTHR_IDX_TIMER);
	assign wr_status   = wr_pend_q && (wr_idx_q == AUXTHR_IDX_STATUS);
	assign wr_mask     = wr_pend_q && (wr_idx_q == AUXTHR_IDX_MASK);

	// ==========================================================
	// Channel selection: temperature overrides the external converter
	logic temp_on, ext_on, chan_on, smp_ok;
	assign temp_on = ctl_q[AUXTHR_CTL_TEMP_EN];
	assign ext_on  = ctl_q[AUXTHR_CTL_EXT_EN] && !temp_on;           // R12
	assign chan_on = temp_on || ext_on;
	// Only samples of the live source count, so stale converter data is dropped
	assign smp_ok  = SMP_I.valid && chan_on && (SMP_I.is_temp == temp_on); // R12

	// ==========================================================
	// Threshold assembly and magnitude compare
	logic [AUXTHR_THR_W-1:0] act_thr, quiet_thr;
	logic [AUXTHR_SMP_W-1:0] mag;
	logic                    is_act, is_quiet;
	assign act_thr   = {act_up_q, act_lo_q};                          // R13
	assign quiet_thr = {quiet_up_q, quiet_lo_q};                      // R13
	// Magnitude of -8192 is 8192, which needs the full 14 bits unsigned
	assign mag       = SMP_I.data[AUXTHR_SMP_W-1] ? AUXTHR_SMP_W'(-SMP_I.data)
		: AUXTHR_SMP_W'(SMP_I.data);                                   // R3
	// Raw codes on both sides, no scaling
	assign is_act    = mag > {1'b0, act_thr};                         // R1 R4
	assign is_quiet  = mag < {1'b0, quiet_thr};                       // R2 R4

	// ==========================================================
	// Consecutive-sample qualification
	logic act_smp, quiet_smp, act_fire, quiet_fire;
	assign act_smp   = smp_ok && ctl_q[AUXTHR_CTL_ACT_EN];
	assign quiet_smp = smp_ok && ctl_q[AUXTHR_CTL_QUIET_EN];

	auxthr_cnt #(.CNT_W(AUXTHR_CNT_W)) u_act_cnt (
		.clk_i  (CLK_SYS_I),
		.rst_i  (RST_I),
		.smp_i  (act_smp),
		.hit_i  (is_act),
		.need_i (timer_q[AUXTHR_ACT_CNT_LSB +: AUXTHR_CNT_W]),    // R10
		.evt_o  (act_fire)
	);

	auxthr_cnt #(.CNT_W(AUXTHR_CNT_W)) u_quiet_cnt (
		.clk_i  (CLK_SYS_I),
		.rst_i  (RST_I),
		.smp_i  (quiet_smp),
		.hit_i  (is_quiet),
		.need_i (timer_q[AUXTHR_QUIET_CNT_LSB +: AUXTHR_CNT_W]),  // R11
		.evt_o  (quiet_fire)
	);

	// ==========================================================
	// Sticky status: a new event wins over a write-one clear
	logic [AUXTHR_ST_W-1:0] evt_vec, clr_vec, status_d;
	assign evt_vec  = {quiet_fire, act_fire};
	assign clr_vec  = wr_status ? wbyte[AUXTHR_ST_W-1:0] : '0;
	assign status_d = (status_q & ~clr_vec) | evt_vec;

	// ==========================================================
	// Bus front end: zero wait states, read data registered at address phase
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			wr_pend_q   <= 1'b0;
			wr_idx_q    <= 8'h00;
			HRDATA_O    <= 32'h0000_0000;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end else begin
			wr_pend_q <= addr_take && HWRITE_I && addr_word;
			wr_idx_q  <= addr_idx;
			if (addr_take && !HWRITE_I) begin
				HRDATA_O <= {24'h00_0000, addr_word ? rd_byte(addr_idx, act_up_q, act_lo_q,
					quiet_up_q, quiet_lo_q, ctl_q, timer_q, status_q, mask_q,
					{is_quiet, is_act}) : 8'h00};
			end
		end
	end

	// Threshold registers; reserved bits are never stored
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			act_up_q   <= AUXTHR_RST_BYTE[AUXTHR_UPPER_W-1:0];        // R5
			act_lo_q   <= AUXTHR_RST_BYTE[AUXTHR_LOWER_W-1:0];        // R6
			quiet_up_q <= AUXTHR_RST_BYTE[AUXTHR_UPPER_W-1:0];        // R7
			quiet_lo_q <= AUXTHR_RST_BYTE[AUXTHR_LOWER_W-1:0];        // R8
		end else begin
			if (wr_act_up) begin
				act_up_q <= wbyte[AUXTHR_UPPER_W-1:0];                 // R5 R9
			end
			if (wr_act_lo) begin
				act_lo_q <= wbyte[AUXTHR_LOWER_LSB +: AUXTHR_LOWER_W]; // R6 R9
			end
			if (wr_quiet_up) begin
				quiet_up_q <= wbyte[AUXTHR_UPPER_W-1:0];               // R7 R9
			end
			if (wr_quiet_lo) begin
				quiet_lo_q <= wbyte[AUXTHR_LOWER_LSB +: AUXTHR_LOWER_W]; // R8 R9
			end
		end
	end

	// Control, timer, status and mask registers
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			ctl_q    <= AUXTHR_RST_BYTE;
			timer_q  <= AUXTHR_RST_BYTE;
			status_q <= '0;
			mask_q   <= '0;
		end else begin
			status_q <= status_d;
			if (wr_ctl) begin
				ctl_q <= wbyte & AUXTHR_CTL_WMASK;
			end
			if (wr_timer) begin
				timer_q <= wbyte;
			end
			if (wr_mask) begin
				mask_q <= wbyte[AUXTHR_ST_W-1:0];
			end
		end
	end

	// ==========================================================
	// Registered outputs; the interrupt sees status one cycle later
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			EXT_CONV_EN_O <= 1'b0;
			ACT_EVT_O     <= 1'b0;
			QUIET_EVT_O   <= 1'b0;
			IRQ_O         <= 1'b0;
		end else begin
			EXT_CONV_EN_O <= ext_on;                                   // R12
			ACT_EVT_O     <= act_fire;                                 // R10
			QUIET_EVT_O   <= quiet_fire;                               // R11
			IRQ_O         <= |(status_q & mask_q);
		end
	end
endmodule

`default_nettype wire

// File: tb/auxthr_monitor.sv
// Port checker for the auxiliary threshold detector.
// Assumes it is bound onto auxthr_top with the default address width.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module auxthr_monitor
	import auxthr_pkg::*;
(
	// Clock and reset
	input wire logic                  CLK_SYS_I,
	input wire logic                  RST_I,
	// Bus
	input wire logic                  HSEL_I,
	input wire logic [31:0]           HADDR_I,
	input wire logic [1:0]            HTRANS_I,
	input wire logic                  HWRITE_I,
	input wire logic                  HREADY_I,
	input wire logic [31:0]           HRDATA_O,
	input wire logic                  HREADYOUT_O,
	input wire logic                  HRESP_O,
	// Samples and events
	input wire auxthr_pkg::auxthr_sample_s SMP_I,
	input wire logic                  ACT_EVT_O,
	input wire logic                  QUIET_EVT_O
);
	// Read address phase and its register index
	wire       rd_take = HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I;
	wire [7:0] idx     = HADDR_I[9:2];
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	a_bus_okay: assert property (HREADYOUT_O && !HRESP_O) else $error("bus answer not ready or not OKAY");
	a_act_upper: assert property (rd_take && idx == AUXTHR_IDX_ACT_UPPER |=> HRDATA_O[31:7] == 25'h0)
		else $error("activity upper reserved bits set");
	a_act_lower: assert property (rd_take && idx == AUXTHR_IDX_ACT_LOWER |=> HRDATA_O[1:0] == 2'h0)
		else $error("activity lower reserved bits set");
	a_quiet_upper: assert property (rd_take && idx == AUXTHR_IDX_QUIET_UPPER |=> !HRDATA_O[7])
		else $error("quiet upper reserved bit set");
	a_quiet_lower: assert property (rd_take && idx == AUXTHR_IDX_QUIET_LOWER |=> HRDATA_O[1:0] == 2'h0)
		else $error("quiet lower reserved bits set");
	// Read data must not wander between reads
	a_rdata_hold: assert property (!$past(rd_take) |-> $stable(HRDATA_O)) else $error("read data moved");
	a_act_cause: assert property (ACT_EVT_O |-> $past(SMP_I.valid, 2) && $past(SMP_I.data, 2) != 14'sh0)
		else $error("activity event without a large sample");
	a_quiet_cause: assert property (QUIET_EVT_O |-> $past(SMP_I.valid, 2) && $past(SMP_I.data, 2) != 14'sh2000)
		else $error("quiet event without a small sample");
	a_act_once: assert property (ACT_EVT_O |=> !ACT_EVT_O) else $error("activity event refired");
	a_quiet_once: assert property (QUIET_EVT_O |=> !QUIET_EVT_O) else $error("quiet event refired");
endmodule
bind auxthr_top auxthr_monitor u_mon (.CLK_SYS_I, .RST_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HREADY_I,
	.HRDATA_O, .HREADYOUT_O, .HRESP_O, .SMP_I, .ACT_EVT_O, .QUIET_EVT_O);
`default_nettype wire

// File: tb/auxthr_tb.sv
// Self-checking bench for the auxiliary threshold detector.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench top
module testbench;
	import auxthr_pkg::*;
	logic           clk_sys, rst, hsel, hwrite, rd_pend, hready, hresp, ext_en, act_evt, quiet_evt, irq;
	logic [1:0]     htrans, st;
	logic [31:0]    haddr, hwdata, hrdata;
	logic [13:0]    mag;
	auxthr_sample_s smp;
	logic [31:0]    rd_q[$];
	logic [1:0]     ev_q[$];
	// Boundary codes: full scale, on, just over and mirrored, then the quiet edges
	logic [13:0]    bnd[8] = '{14'h2000, 14'h00c5, 14'h00c6, 14'h3f3a, 14'h00c6, 14'h0041, 14'h0040, 14'h3fc0};
	int             err_total, n_checks, ra, rq, i;
	auxthr_top u_dut (.CLK_SYS_I(clk_sys), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .SMP_I(smp), .EXT_CONV_EN_O(ext_en), .ACT_EVT_O(act_evt),
		.QUIET_EVT_O(quiet_evt), .IRQ_O(irq));
	task automatic results();
		if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t read %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t flags %b want %b", $time, got, exp);
		end
	endtask
	// Bounded wait for hready at a rising edge; no wait state count is assumed
	task automatic tick();
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (hready !== 1'b1) begin
			err_total++;
			results();
		end
	endtask
	// One single transfer; for a read, d is the expected data
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		rd_pend <= 1'b0;
		tick();
		htrans <= 2'h0;
		hwdata <= d;
		rd_pend <= ~w;
		if (!w) rd_q.push_back(d);
		tick();
	endtask
	// One sample; the reference run counters note the events it should cause
	task automatic sample(input logic tmp, input logic [13:0] v);
		logic [1:0] f;
		smp <= '{1'b1, tmp, v};
		if (tmp) begin
			mag = v[13] ? -v : v;
			ra = (mag > 14'h00c5) ? ((ra < 15) ? ra + 1 : 15) : 0;
			rq = (mag < 14'h0041) ? ((rq < 15) ? rq + 1 : 15) : 0;
			f = {ra == 3, rq == 2};
			if (f != 2'h0) ev_q.push_back(f);
			st = st | f;
		end
		@(posedge clk_sys);
		smp.valid <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Result watcher: oldest note against each result that appears
	always @(posedge clk_sys) begin
		if (rd_pend === 1'b1 && hready === 1'b1 && rd_q.size() > 0) cmp_rd(hrdata, rd_q.pop_front());
		if (act_evt === 1'b1 || quiet_evt === 1'b1) cmp_bit({act_evt, quiet_evt}, (ev_q.size() > 0) ? ev_q.pop_front() : 2'h0);
	end
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_sys);
		err_total++;
		results();
	end
	initial begin
		{rst, hsel, hwrite, rd_pend, htrans, haddr, hwdata, smp} = '0;
		rst = 1'b1;
		{err_total, n_checks, ra, rq, st} = '0;
		void'($urandom(32'h383c8d84));
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		// Reset value, then all-ones write shows which bits are kept
		for (i = 0; i < 4; i++) begin
			bus(1'b0, 8'(AUXTHR_IDX_ACT_UPPER + i), 32'h0);
			bus(1'b1, 8'(AUXTHR_IDX_ACT_UPPER + i), 32'hffffffff);
			bus(1'b0, 8'(AUXTHR_IDX_ACT_UPPER + i), i[0] ? 32'hfc : 32'h7f);
		end
		bus(1'b1, 8'h00, 32'hff);
		bus(1'b0, 8'h00, 32'h0);
		// Activity level 0x0c5 and quiet level 0x041 split over two bytes each
		bus(1'b1, AUXTHR_IDX_ACT_UPPER, 32'h03);
		bus(1'b1, AUXTHR_IDX_ACT_LOWER, 32'h14);
		bus(1'b1, AUXTHR_IDX_QUIET_UPPER, 32'h01);
		bus(1'b1, AUXTHR_IDX_QUIET_LOWER, 32'h04);
		bus(1'b0, AUXTHR_IDX_ACT_LOWER, 32'h14);
		bus(1'b1, AUXTHR_IDX_TIMER, 32'h23);
		bus(1'b1, AUXTHR_IDX_CTRL, 32'h10);
		repeat (2) @(posedge clk_sys);
		cmp_bit({1'b0, ext_en}, 2'h1);
		bus(1'b1, AUXTHR_IDX_CTRL, 32'h1b);
		repeat (2) @(posedge clk_sys);
		cmp_bit({1'b0, ext_en}, 2'h0);
		// Boundary codes, then random traffic with stray external samples
		foreach (bnd[j]) sample(1'b1, bnd[j]);
		for (i = 0; i < 300; i++) sample($urandom_range(7, 0) != 0, 14'($urandom_range(32'h320, 0) - 32'h190));
		repeat (4) @(posedge clk_sys);
		cmp_rd(ev_q.size(), 32'h0);
		cmp_bit({1'b0, irq}, 2'h0);
		bus(1'b0, AUXTHR_IDX_STATUS, {30'h0, st});
		bus(1'b1, AUXTHR_IDX_MASK, 32'h3);
		repeat (2) @(posedge clk_sys);
		cmp_bit({1'b0, irq}, {1'b0, |st});
		bus(1'b1, AUXTHR_IDX_STATUS, 32'h3);
		bus(1'b0, AUXTHR_IDX_STATUS, 32'h0);
		repeat (2) @(posedge clk_sys);
		cmp_bit({1'b0, irq}, 2'h0);
		hsel <= 1'b0;
		rd_pend <= 1'b0;
		@(posedge clk_sys);
		results();
	end
endmodule
`default_nettype wire
